//--- rtl/lfbc_pkg.sv
// Purpose: Shared constants for the fault threshold and brightness configuration bank
// Assumes: 32-bit register port, byte addresses, one aligned word per register
// Notes:   Threshold tables are in millivolts, index is the field code
package lfbc_pkg;

    // ----------------------------------------------------------------
    // Register port geometry
    // ----------------------------------------------------------------
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int CFG_W = 48;
    localparam int CH_N = 48;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CFG_LO   = 8'h00;
    localparam logic [7:0] OFS_CFG_HI   = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_OPEN_LO  = 8'h0C;
    localparam logic [7:0] OFS_OPEN_HI  = 8'h10;
    localparam logic [7:0] OFS_SHORT_LO = 8'h14;
    localparam logic [7:0] OFS_SHORT_HI = 8'h18;

    // ----------------------------------------------------------------
    // Field positions inside the 48-bit configuration register
    // ----------------------------------------------------------------
    localparam int RED_OPEN_LSB    = 0;
    localparam int GREEN_OPEN_LSB  = 2;
    localparam int BLUE_OPEN_LSB   = 4;
    localparam int RSVD_BIT        = 6;
    localparam int READBACK_BIT    = 7;
    localparam int RED_LEVEL_LSB   = 8;
    localparam int GREEN_LEVEL_LSB = 16;
    localparam int BLUE_LEVEL_LSB  = 24;
    localparam int GLOBAL_LSB      = 32;
    localparam int REMOVAL_LSB     = 35;
    localparam int RED_SHORT_LSB   = 39;
    localparam int GREEN_SHORT_LSB = 42;
    localparam int BLUE_SHORT_LSB  = 45;

    // ----------------------------------------------------------------
    // Reset value and writable bits
    // ----------------------------------------------------------------
    localparam logic [47:0] CFG_RESET = 48'h003B_7F7F_7F00;
    localparam logic [47:0] CFG_WMASK = 48'hFFFF_FFFF_FFBF;

    // ----------------------------------------------------------------
    // Status word field positions
    // ----------------------------------------------------------------
    localparam int ST_REMOVAL_LSB = 0;
    localparam int ST_READBACK    = 8;
    localparam int ST_ANY_OPEN    = 16;
    localparam int ST_ANY_SHORT   = 17;

    // ----------------------------------------------------------------
    // Threshold tables in millivolts, element index equals field code
    // ----------------------------------------------------------------
    localparam logic [3:0][11:0] OPEN_MV = {12'h4B0, 12'h384, 12'h1F4, 12'h0C8};
    localparam logic [7:0][11:0] SHORT_MV_RED = {12'h708, 12'h640, 12'h578, 12'h4B0,
                                                 12'h3E8, 12'h320, 12'h190, 12'h0C8};
    localparam logic [7:0][11:0] SHORT_MV_GB = {12'hAF0, 12'h960, 12'h7D0, 12'h640,
                                                12'h4B0, 12'h320, 12'h190, 12'h0C8};

endpackage : lfbc_pkg

//--- rtl/lfbc_sync.sv
// Purpose: Two-stage synchroniser for a bundle of independent level flags
// Assumes: Each bit is a slow level; no multi-bit coherence is needed
// Notes:   Only the second stage may be read by other logic
`timescale 1ns/100ps
`default_nettype none
module lfbc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset,
    // Flags
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : lfbc_sync
`default_nettype wire

//--- rtl/lfbc_vth_dec.sv
// Purpose: Turns one colour's threshold codes into millivolt figures
// Assumes: Codes come straight from the configuration register
// Notes:   RED_TABLE selects the narrower short threshold table of red
`timescale 1ns/100ps
`default_nettype none
module lfbc_vth_dec
    import lfbc_pkg::*;
#(
    parameter bit RED_TABLE = 1'b0
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // Codes
    input  wire logic [1:0]  open_code,
    input  wire logic [2:0]  short_code,
    // Millivolt figures
    output logic      [11:0] open_mv,
    output logic      [11:0] short_mv
);

    logic [11:0] open_mv_ff;
    logic [11:0] short_mv_ff;

    // Registered lookup; reset shows the code 0 figures
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            open_mv_ff  <= OPEN_MV[0];
            short_mv_ff <= SHORT_MV_GB[0];
        end else begin
            open_mv_ff  <= OPEN_MV[open_code];
            short_mv_ff <= RED_TABLE ? SHORT_MV_RED[short_code] : SHORT_MV_GB[short_code];
        end
    end

    assign open_mv  = open_mv_ff;
    assign short_mv = short_mv_ff;

endmodule : lfbc_vth_dec
`default_nettype wire

//--- rtl/lfbc_top.sv
// Purpose: Fault threshold and brightness configuration register bank
// Assumes: Plain register port, read data valid the cycle after the strobe
// Notes:   Fault flags arrive from analog detectors and are synchronised
//
// Behaviour
// - Red open threshold, bits 1-0, reset 00
// - Green open threshold, bits 3-2, reset 00
// - Blue open threshold, bits 5-4, reset 00
// - Bit 7 enables fault result readback
// - Red colour level, bits 15-8, reset 127
// - Green colour level, bits 23-16, reset 127
// - Blue colour level, bits 31-24, reset 127
// - Global brightness, bits 34-32, reset 011
// - Short removal level, bits 38-35, reset 0111
// - Red short threshold, bits 41-39, reset 000
// - Green short threshold, bits 44-42, reset 000
// - Blue short threshold, bits 47-45, reset 000
`timescale 1ns/100ps
`default_nettype none
module lfbc_top
    import lfbc_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset,

    // Register port
    input  wire logic [AW-1:0]     reg_addr,
    input  wire logic [DW-1:0]     reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DW-1:0]     reg_rdata,

    // Fault flags from the detectors
    input  wire logic [CH_N-1:0]   open_fault_in,
    input  wire logic [CH_N-1:0]   short_fault_in,

    // Open load thresholds
    output logic      [1:0]        red_open_threshold,
    output logic      [1:0]        green_open_threshold,
    output logic      [1:0]        blue_open_threshold,

    // Readback control
    output logic                   fault_readback_enable,

    // Brightness levels
    output logic      [7:0]        red_colour_level,
    output logic      [7:0]        green_colour_level,
    output logic      [7:0]        blue_colour_level,
    output logic      [2:0]        global_brightness_level,

    // Short handling
    output logic      [3:0]        short_removal_level,
    output logic      [2:0]        red_short_threshold,
    output logic      [2:0]        green_short_threshold,
    output logic      [2:0]        blue_short_threshold,

    // Decoded thresholds in millivolts
    output logic      [11:0]       red_open_mv,
    output logic      [11:0]       green_open_mv,
    output logic      [11:0]       blue_open_mv,
    output logic      [11:0]       red_short_mv,
    output logic      [11:0]       green_short_mv,
    output logic      [11:0]       blue_short_mv
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Address match against a register offset
    function automatic logic addr_hit(input logic [AW-1:0] addr,
                                      input logic [AW-1:0] ofs);
        addr_hit = (addr == ofs);
    endfunction : addr_hit

    // Merge new bits into an old value, keeping read-only bits
    function automatic logic [CFG_W-1:0] merge_bits(input logic [CFG_W-1:0] old_val,
                                                     input logic [CFG_W-1:0] new_val,
                                                     input logic [CFG_W-1:0] sel);
        logic [CFG_W-1:0] keep;
        keep       = sel & CFG_WMASK;
        merge_bits = (old_val & ~keep) | (new_val & keep);
    endfunction : merge_bits

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [CFG_W-1:0] cfg_ff;
    logic [CFG_W-1:0] nxt_cfg;
    logic [DW-1:0]    rdata_ff;
    logic [DW-1:0]    nxt_rdata;
    logic [CH_N-1:0]  open_sync;
    logic [CH_N-1:0]  short_sync;
    logic [CH_N-1:0]  open_seen_ff;
    logic [CH_N-1:0]  short_seen_ff;
    logic             any_open;
    logic             any_short;
    logic [4:0]       removal_step;
    logic [DW-1:0]    status_word;

    // ----------------------------------------------------------------
    // Fault flag synchronisers
    // ----------------------------------------------------------------

    // Detector outputs settle on their own timing, so they cross here
    lfbc_sync #(
        .W        (CH_N)
    ) u_open_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (open_fault_in),
        .sync_out (open_sync)
    );

    lfbc_sync #(
        .W        (CH_N)
    ) u_short_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (short_fault_in),
        .sync_out (short_sync)
    );

    // ----------------------------------------------------------------
    // Configuration register write path
    // ----------------------------------------------------------------

    // Word writes land on their half; reserved bit 6 never takes a value
    always_comb begin
        nxt_cfg = cfg_ff;
        if (reg_wr && addr_hit(reg_addr, OFS_CFG_LO)) begin
            nxt_cfg = merge_bits(cfg_ff, {16'h0000, reg_wdata}, 48'h0000_FFFF_FFFF);
        end else if (reg_wr && addr_hit(reg_addr, OFS_CFG_HI)) begin
            nxt_cfg = merge_bits(cfg_ff, {reg_wdata[15:0], 32'h0000_0000}, 48'hFFFF_0000_0000);
        end
    end

    // Whole register takes its documented reset pattern
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg_ff <= CFG_RESET;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // ----------------------------------------------------------------
    // Field outputs
    // ----------------------------------------------------------------

    // Open load thresholds, offsets below each colour supply
    assign red_open_threshold   = cfg_ff[RED_OPEN_LSB +: 2];
    assign green_open_threshold = cfg_ff[GREEN_OPEN_LSB +: 2];
    assign blue_open_threshold  = cfg_ff[BLUE_OPEN_LSB +: 2];

    // Readback switch, off after reset
    assign fault_readback_enable = cfg_ff[READBACK_BIT];

    // Colour levels run linearly from 0 to 255
    assign red_colour_level   = cfg_ff[RED_LEVEL_LSB +: 8];
    assign green_colour_level = cfg_ff[GREEN_LEVEL_LSB +: 8];
    assign blue_colour_level  = cfg_ff[BLUE_LEVEL_LSB +: 8];

    // Global level, eight steps
    assign global_brightness_level = cfg_ff[GLOBAL_LSB +: 3];

    // Removal level code; the level itself is code plus one
    assign short_removal_level = cfg_ff[REMOVAL_LSB +: 4];
    assign removal_step        = {1'b0, short_removal_level} + 5'h01;

    // Short and weak-short thresholds
    assign red_short_threshold   = cfg_ff[RED_SHORT_LSB +: 3];
    assign green_short_threshold = cfg_ff[GREEN_SHORT_LSB +: 3];
    assign blue_short_threshold  = cfg_ff[BLUE_SHORT_LSB +: 3];

    // ----------------------------------------------------------------
    // Threshold decoders
    // ----------------------------------------------------------------

    // Red uses its own short table, topping out lower than green and blue
    lfbc_vth_dec #(
        .RED_TABLE  (1'b1)
    ) u_red_dec (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .open_code  (red_open_threshold),
        .short_code (red_short_threshold),
        .open_mv    (red_open_mv),
        .short_mv   (red_short_mv)
    );

    lfbc_vth_dec #(
        .RED_TABLE  (1'b0)
    ) u_green_dec (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .open_code  (green_open_threshold),
        .short_code (green_short_threshold),
        .open_mv    (green_open_mv),
        .short_mv   (green_short_mv)
    );

    // Blue shares the green short table
    lfbc_vth_dec #(
        .RED_TABLE  (1'b0)
    ) u_blue_dec (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .open_code  (blue_open_threshold),
        .short_code (blue_short_threshold),
        .open_mv    (blue_open_mv),
        .short_mv   (blue_short_mv)
    );

    // ----------------------------------------------------------------
    // Fault result capture
    // ----------------------------------------------------------------

    // Results follow the synchronised flags each cycle only while readback is on; turning it off clears
    // them so stale faults never reappear after a later enable
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            open_seen_ff <= '0;
        end else if (!fault_readback_enable) begin
            open_seen_ff <= '0;
        end else begin
            open_seen_ff <= open_sync;
        end
    end

    // Short results follow the same gating
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            short_seen_ff <= '0;
        end else if (!fault_readback_enable) begin
            short_seen_ff <= '0;
        end else begin
            short_seen_ff <= short_sync;
        end
    end

    // Summary flags for the status word
    assign any_open  = |open_seen_ff;
    assign any_short = |short_seen_ff;

    // ----------------------------------------------------------------
    // Status word
    // ----------------------------------------------------------------

    // Live view of the derived removal level and fault summaries
    always_comb begin
        status_word = '0;
        status_word[ST_REMOVAL_LSB +: 5] = removal_step;
        status_word[ST_READBACK]         = fault_readback_enable;
        status_word[ST_ANY_OPEN]         = any_open;
        status_word[ST_ANY_SHORT]        = any_short;
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------

    // Unmapped offsets answer zero; reserved bit 6 is never stored
    always_comb begin
        nxt_rdata = '0;
        if (reg_rd) begin
            unique case (1'b1)
                addr_hit(reg_addr, OFS_CFG_LO):   nxt_rdata = cfg_ff[31:0];
                addr_hit(reg_addr, OFS_CFG_HI):   nxt_rdata = {16'h0000, cfg_ff[47:32]};
                addr_hit(reg_addr, OFS_STATUS):   nxt_rdata = status_word;
                addr_hit(reg_addr, OFS_OPEN_LO):  nxt_rdata = open_seen_ff[31:0];
                addr_hit(reg_addr, OFS_OPEN_HI):  nxt_rdata = {16'h0000, open_seen_ff[47:32]};
                addr_hit(reg_addr, OFS_SHORT_LO): nxt_rdata = short_seen_ff[31:0];
                addr_hit(reg_addr, OFS_SHORT_HI): nxt_rdata = {16'h0000, short_seen_ff[47:32]};
                default:                          nxt_rdata = '0;
            endcase
        end
    end

    // Data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule : lfbc_top
`default_nettype wire

//--- bench/lfbc_top_sva.sv
// Purpose: Port assertions for the fault threshold and brightness bank
// Assumes: One clock, synchronous active-high reset, bus as in the hand-over
// Notes:   Bound to every lfbc_top instance at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module lfbc_top_sva
    import lfbc_pkg::*;
(
    // Clock and reset
    input wire logic          ref_clk,
    input wire logic          reset,
    // Register port
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic          reg_wr,
    input wire logic          reg_rd,
    input wire logic [DW-1:0] reg_rdata,
    // Field outputs
    input wire logic [1:0]    red_open_threshold,
    input wire logic [1:0]    green_open_threshold,
    input wire logic [1:0]    blue_open_threshold,
    input wire logic          fault_readback_enable,
    input wire logic [7:0]    red_colour_level,
    input wire logic [7:0]    green_colour_level,
    input wire logic [7:0]    blue_colour_level,
    input wire logic [2:0]    global_brightness_level,
    input wire logic [3:0]    short_removal_level,
    input wire logic [2:0]    red_short_threshold,
    input wire logic [2:0]    green_short_threshold,
    input wire logic [2:0]    blue_short_threshold,
    // Decoded thresholds
    input wire logic [11:0]   red_open_mv,
    input wire logic [11:0]   red_short_mv,
    input wire logic [11:0]   green_short_mv
);
    // ----------------------------------------------------------------
    // Field views of both words, bit 6 shown as the zero it must read
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic [31:0] lo_v = {blue_colour_level, green_colour_level, red_colour_level,
        fault_readback_enable, 1'b0, blue_open_threshold, green_open_threshold, red_open_threshold};
    wire logic [15:0] hi_v = {blue_short_threshold, green_short_threshold, red_short_threshold,
        short_removal_level, global_brightness_level};
    wire logic wr_lo = reg_wr && (reg_addr == OFS_CFG_LO);
    wire logic wr_hi = reg_wr && (reg_addr == OFS_CFG_HI);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside the answer cycle");
    lo_write_a: assert property (wr_lo |=> lo_v == ($past(reg_wdata) & 32'hFFFF_FFBF))
        else $error("low word fields differ from written data");
    hi_write_a: assert property (wr_hi |=> hi_v == $past(reg_wdata[15:0]))
        else $error("high word fields differ from written data");
    cfg_hold_a: assert property (!(wr_lo || wr_hi) |=> $stable(lo_v) && $stable(hi_v))
        else $error("fields moved without a write");
    rd_low_a: assert property (reg_rd && reg_addr == OFS_CFG_LO |=> reg_rdata == lo_v)
        else $error("low word read does not match fields");
    rd_high_a: assert property (reg_rd && reg_addr == OFS_CFG_HI |=> reg_rdata == {16'h0000, hi_v})
        else $error("high word read does not match fields");
    red_open_a: assert property (red_open_mv == OPEN_MV[$past(red_open_threshold)])
        else $error("red open figure wrong");
    red_short_a: assert property (red_short_mv == SHORT_MV_RED[$past(red_short_threshold)])
        else $error("red short figure wrong");
    green_short_a: assert property (green_short_mv == SHORT_MV_GB[$past(green_short_threshold)])
        else $error("green short figure wrong");

    // Main scenarios reached
    cover property (wr_lo);
    cover property (wr_hi);
    cover property (reg_rd && reg_addr == OFS_CFG_LO);
    cover property (reg_rd && reg_addr == OFS_STATUS);
endmodule : lfbc_top_sva

bind lfbc_top lfbc_top_sva chk_u (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .red_open_threshold, .green_open_threshold, .blue_open_threshold,
    .fault_readback_enable, .red_colour_level, .green_colour_level, .blue_colour_level,
    .global_brightness_level, .short_removal_level, .red_short_threshold,
    .green_short_threshold, .blue_short_threshold, .red_open_mv, .red_short_mv, .green_short_mv);
`default_nettype wire

//--- bench/lfbc_tb_top.sv
// Purpose: Self-checking bench for the fault threshold and brightness bank
// Assumes: Read data sampled at the edge closing the answer cycle
// Notes:   Expected values come from the field map, not from the design
`timescale 1ns/100ps
`default_nettype none
module lfbc_tb_top
    import lfbc_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} lfbc_row_t;
    logic ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, fault_readback_enable;
    logic [7:0] reg_addr = 8'h00, red_colour_level, green_colour_level, blue_colour_level;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
    logic [47:0] open_fault_in = 48'h0, short_fault_in = 48'h0, exp_cfg;
    logic [1:0] red_open_threshold, green_open_threshold, blue_open_threshold;
    logic [2:0] global_brightness_level, red_short_threshold, green_short_threshold, blue_short_threshold;
    logic [3:0] short_removal_level;
    logic [11:0] red_open_mv, green_open_mv, blue_open_mv, red_short_mv, green_short_mv, blue_short_mv;
    int fail_count = 0, check_count = 0;
    int open_tab[4] = '{200, 500, 900, 1200};
    int rsh_tab[8] = '{200, 400, 800, 1000, 1200, 1400, 1600, 1800};
    int gsh_tab[8] = '{200, 400, 800, 1200, 1600, 2000, 2400, 2800};
    wire logic [47:0] cfg_now = {blue_short_threshold, green_short_threshold, red_short_threshold,
        short_removal_level, global_brightness_level, blue_colour_level, green_colour_level,
        red_colour_level, fault_readback_enable, 1'b0, blue_open_threshold, green_open_threshold,
        red_open_threshold};
    // Bit 6 written high must read back low; unmapped and fault places ignore writes
    lfbc_row_t rows[9] = '{'{8'h00, 32'hFFFF_FFFF, 32'hFFFF_FFBF}, '{8'h00, 32'h0000_0040, 32'h0},
        '{8'h00, 32'hA5C3_3C96, 32'hA5C3_3C96}, '{8'h04, 32'hFFFF_FFFF, 32'h0000_FFFF},
        '{8'h04, 32'h1234_5678, 32'h0000_5678}, '{8'h04, 32'h0, 32'h0},
        '{8'h0C, 32'hFFFF_FFFF, 32'h0}, '{8'h1C, 32'hFFFF_FFFF, 32'h0}, '{8'h04, 32'h0000_ABCD, 32'h0000_ABCD}};

    lfbc_top dut_u (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .open_fault_in, .short_fault_in, .red_open_threshold, .green_open_threshold,
        .blue_open_threshold, .fault_readback_enable, .red_colour_level, .green_colour_level,
        .blue_colour_level, .global_brightness_level, .short_removal_level, .red_short_threshold,
        .green_short_threshold, .blue_short_threshold, .red_open_mv, .green_open_mv, .blue_open_mv,
        .red_short_mv, .green_short_mv, .blue_short_mv);

    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // Bus and compare tasks, entered just after a rising edge
    // ----------------------------------------------------------------
    task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk_val

    // Strobe left high so back-to-back writes need no idle cycle between them
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
    endtask : wr_reg

    task automatic idle(input int n);
        reg_wr <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask : idle

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        check_count++;
        if (reg_rdata !== e) begin
            fail_count++;
            $display("wrong value at %0t: read %h at %h, expected %h", $time, reg_rdata, a, e);
        end
    endtask : rd_chk

    task automatic test_done;
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        exp_cfg = 48'h003B_7F7F_7F00;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        // Table rows: write, read back straight after, compare field outputs
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            if (rows[i].a == OFS_CFG_LO) exp_cfg[31:0] = rows[i].d & 32'hFFFF_FFBF;
            if (rows[i].a == OFS_CFG_HI) exp_cfg[47:32] = rows[i].d[15:0];
            rd_chk(rows[i].a, rows[i].e);
            chk_val(cfg_now, exp_cfg);
        end
        // Every threshold code and its decoded figure
        for (int i = 0; i < 8; i++) begin
            wr_reg(OFS_CFG_LO, {24'h7F7F7F, 2'b00, 6'((i % 4) * 21)});
            wr_reg(OFS_CFG_HI, 32'({3'(i), 3'(i), 3'(i), 7'h3B}));
            idle(2);
            chk_val(48'(red_open_mv), 48'(open_tab[i % 4]));
            chk_val(48'(green_open_mv), 48'(open_tab[i % 4]));
            chk_val(48'(blue_open_mv), 48'(open_tab[i % 4]));
            chk_val(48'(red_short_mv), 48'(rsh_tab[i]));
            chk_val(48'(green_short_mv), 48'(gsh_tab[i]));
            chk_val(48'(blue_short_mv), 48'(gsh_tab[i]));
        end
        // Fault results hidden while readback is off, shown once it is on
        open_fault_in <= 48'h8000_0000_0001;
        short_fault_in <= 48'h0000_0010_0000;
        idle(5);
        rd_chk(OFS_OPEN_LO, 32'h0);
        wr_reg(OFS_CFG_LO, 32'h7F7F_7F80);
        idle(4);
        rd_chk(OFS_OPEN_LO, 32'h0000_0001);
        rd_chk(OFS_OPEN_HI, 32'h0000_8000);
        rd_chk(OFS_SHORT_LO, 32'h0010_0000);
        rd_chk(OFS_SHORT_HI, 32'h0);
        rd_chk(OFS_STATUS, 32'h0003_0108);
        wr_reg(OFS_CFG_LO, 32'h7F7F_7F00);
        idle(2);
        rd_chk(OFS_OPEN_LO, 32'h0);
        // Reset in mid-run restores every field
        reset <= 1'b1;
        idle(3);
        reset <= 1'b0;
        @(posedge ref_clk);
        chk_val(cfg_now, 48'h003B_7F7F_7F00);
        rd_chk(OFS_CFG_LO, 32'h7F7F_7F00);
        rd_chk(OFS_CFG_HI, 32'h0000_003B);
        test_done();
    end

    // Watchdog: the sequence needs about 105 cycles
    initial begin
        repeat (3000) @(posedge ref_clk);
        fail_count++;
        test_done();
    end
endmodule : lfbc_tb_top
`default_nettype wire
